// ### sirq_regs.sv
// axi4-lite register bank for two serial channels' interrupt flags and enables
// assumes channel events and soft resets come from logic on clk_i
`timescale 1ns/1ps
module sirq_regs
  import sirq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ch0_soft_reset_i,
  input wire logic ch1_soft_reset_i,
  input wire logic ch0_tx_empty_i,
  input wire logic ch0_rx_done_i,
  input wire logic ch1_tx_empty_i,
  input wire logic ch1_rx_done_i,
  input wire logic [5:0] ch0_foreign_flags_i,
  input wire logic [5:0] ch0_foreign_enables_i,
  input wire logic [1:0] ch1_foreign_i,
  output logic ch0_tx_irq_o,
  output logic ch0_rx_irq_o,
  output logic ch1_tx_irq_o,
  output logic ch1_rx_irq_o
);
  // =====================================================
  // bus state
  typedef struct packed {
    logic aw_held;
    logic [3:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic awready;
    logic wready;
    logic arready;
  } sirq_bus_t;
  sirq_bus_t b_reg, b_next;
  // readies leave a flip-flop, so they reset high
  localparam sirq_bus_t SIRQ_BUS_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                         default: '0};

  logic [1:0] ch0_flags, ch0_en, ch1_flags, ch1_en;
  logic do_write, lane0;
  logic we_f0, we_e0, we_e1, we_f1;
  logic [7:0] rd_byte;
  logic rd_ok, wr_ok;

  assign do_write = b_reg.aw_held & b_reg.w_held & ~b_reg.bvalid;
  assign lane0 = b_reg.wstrb[0];
  assign we_f0 = do_write & lane0 & sirq_hit(b_reg.awaddr, SIRQ_OFS_CH0_FLAGS);
  assign we_e0 = do_write & lane0 & sirq_hit(b_reg.awaddr, SIRQ_OFS_CH0_ENABLES);
  assign we_e1 = do_write & lane0 & sirq_hit(b_reg.awaddr, SIRQ_OFS_CH1_ENABLES);
  assign we_f1 = do_write & lane0 & sirq_hit(b_reg.awaddr, SIRQ_OFS_CH1_FLAGS);
  assign wr_ok = sirq_hit(b_reg.awaddr, SIRQ_OFS_CH0_FLAGS) |
                 sirq_hit(b_reg.awaddr, SIRQ_OFS_CH0_ENABLES) |
                 sirq_hit(b_reg.awaddr, SIRQ_OFS_CH1_ENABLES) |
                 sirq_hit(b_reg.awaddr, SIRQ_OFS_CH1_FLAGS);

  // =====================================================
  // channels
  sirq_chan u_ch0 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .soft_reset_i(ch0_soft_reset_i),
    .tx_empty_i(ch0_tx_empty_i),
    .rx_done_i(ch0_rx_done_i),
    .flag_we_i(we_f0),
    .flag_wdata_i(b_reg.wdata[1:0]),
    .en_we_i(we_e0),
    .en_wdata_i(b_reg.wdata[1:0]),
    .flags_o(ch0_flags),
    .enables_o(ch0_en),
    .tx_irq_o(ch0_tx_irq_o),
    .rx_irq_o(ch0_rx_irq_o)
  );
  sirq_chan u_ch1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .soft_reset_i(ch1_soft_reset_i),
    .tx_empty_i(ch1_tx_empty_i),
    .rx_done_i(ch1_rx_done_i),
    .flag_we_i(we_f1),
    .flag_wdata_i(b_reg.wdata[1:0]),
    .en_we_i(we_e1),
    .en_wdata_i(b_reg.wdata[1:0]),
    .flags_o(ch1_flags),
    .enables_o(ch1_en),
    .tx_irq_o(ch1_tx_irq_o),
    .rx_irq_o(ch1_rx_irq_o)
  );

  // =====================================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case (s_axi_araddr_i)
      SIRQ_OFS_CH0_FLAGS: begin
        // foreign bits only mirrored, never stored here
        rd_byte = ({ch0_foreign_flags_i, 2'h0} & SIRQ_CH0_FOREIGN_MASK) |
                  ({6'h00, ch0_flags} & SIRQ_OWN_MASK);
      end
      SIRQ_OFS_CH0_ENABLES: begin
        rd_byte = ({ch0_foreign_enables_i, 2'h0} & SIRQ_CH0_FOREIGN_MASK) |
                  ({6'h00, ch0_en} & SIRQ_OWN_MASK);
      end
      SIRQ_OFS_CH1_ENABLES: begin
        rd_byte = ({4'h0, ch1_foreign_i, 2'h0} & SIRQ_CH1_FOREIGN_MASK) |
                  ({6'h00, ch1_en} & SIRQ_OWN_MASK);
      end
      SIRQ_OFS_CH1_FLAGS: begin
        rd_byte = ({4'h0, ch1_foreign_i, 2'h0} & SIRQ_CH1_FOREIGN_MASK) |
                  ({6'h00, ch1_flags} & SIRQ_OWN_MASK);
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // =====================================================
  // axi4-lite slave
  always_comb begin
    b_next = b_reg;
    if (s_axi_awvalid_i & ~b_reg.aw_held) begin
      b_next.aw_held = 1'b1;
      b_next.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i & ~b_reg.w_held) begin
      b_next.w_held = 1'b1;
      b_next.wdata = s_axi_wdata_i;
      b_next.wstrb = s_axi_wstrb_i;
    end
    if (do_write) begin
      b_next.bvalid = 1'b1;
      b_next.bresp = wr_ok ? SIRQ_RESP_OKAY : SIRQ_RESP_SLVERR;
    end
    if (b_reg.bvalid & s_axi_bready_i) begin
      b_next.bvalid = 1'b0;
      b_next.aw_held = 1'b0;
      b_next.w_held = 1'b0;
    end
    if (b_reg.rvalid & s_axi_rready_i) begin
      b_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i & ~b_reg.rvalid) begin
      b_next.rvalid = 1'b1;
      b_next.rdata = {24'h000000, rd_byte};
      b_next.rresp = rd_ok ? SIRQ_RESP_OKAY : SIRQ_RESP_SLVERR;
    end
    b_next.awready = ~b_next.aw_held;
    b_next.wready = ~b_next.w_held;
    b_next.arready = ~b_next.rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      b_reg <= SIRQ_BUS_RST;
    end else begin
      b_reg <= b_next;
    end
  end

  assign s_axi_awready_o = b_reg.awready;
  assign s_axi_wready_o = b_reg.wready;
  assign s_axi_bvalid_o = b_reg.bvalid;
  assign s_axi_bresp_o = b_reg.bresp;
  assign s_axi_arready_o = b_reg.arready;
  assign s_axi_rvalid_o = b_reg.rvalid;
  assign s_axi_rdata_o = b_reg.rdata;
  assign s_axi_rresp_o = b_reg.rresp;

  // =====================================================
  // checks
  property p_ch0_tx_set;
    @(posedge clk_i) disable iff (reset_i) ch0_tx_empty_i |=> ch0_flags[1];
  endproperty
  a_ch0_tx_set: assert property (p_ch0_tx_set) else $error("ch0 tx flag not set");
  property p_ch0_rx_set;
    @(posedge clk_i) disable iff (reset_i) ch0_rx_done_i & ~ch0_soft_reset_i |=> ch0_flags[0];
  endproperty
  a_ch0_rx_set: assert property (p_ch0_rx_set) else $error("ch0 rx flag not set");
  property p_ch0_foreign;
    @(posedge clk_i) disable iff (reset_i)
      s_axi_arvalid_i & ~b_reg.rvalid & (s_axi_araddr_i == SIRQ_OFS_CH0_FLAGS)
      |=> s_axi_rdata_o[7:2] == $past(ch0_foreign_flags_i);
  endproperty
  a_ch0_foreign: assert property (p_ch0_foreign) else $error("ch0 foreign bits altered");
  property p_ch1_en_write;
    @(posedge clk_i) disable iff (reset_i)
      we_e1 & ~ch1_soft_reset_i |=> ch1_en == $past(b_reg.wdata[1:0]);
  endproperty
  a_ch1_en_write: assert property (p_ch1_en_write) else $error("ch1 enable write lost");
  property p_ch1_rx_set;
    @(posedge clk_i) disable iff (reset_i) ch1_rx_done_i & ~ch1_soft_reset_i |=> ch1_flags[0];
  endproperty
  a_ch1_rx_set: assert property (p_ch1_rx_set) else $error("ch1 rx flag not set");
  property p_ch0_en_write;
    @(posedge clk_i) disable iff (reset_i)
      we_e0 & ~ch0_soft_reset_i |=> ch0_en == $past(b_reg.wdata[1:0]);
  endproperty
  a_ch0_en_write: assert property (p_ch0_en_write) else $error("ch0 enable write lost");
  property p_soft_reset;
    @(posedge clk_i) disable iff (reset_i)
      ch1_soft_reset_i |=> ch1_flags == 2'h2 && ch1_en[0] == 1'b0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset effect missing");
  property p_irq;
    @(posedge clk_i) disable iff (reset_i) ##1 ch0_tx_irq_o == $past(ch0_flags[1] & ch0_en[1]);
  endproperty
  a_irq: assert property (p_irq) else $error("ch0 tx request mismatch");
  property p_clear;
    @(posedge clk_i) disable iff (reset_i)
      we_f1 & ~b_reg.wdata[0] & ~ch1_rx_done_i & ~ch1_soft_reset_i |=> ~ch1_flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag clear lost");
  property p_ch1_tx_set;
    @(posedge clk_i) disable iff (reset_i) ch1_tx_empty_i |=> ch1_flags[1];
  endproperty
  a_ch1_tx_set: assert property (p_ch1_tx_set) else $error("ch1 tx flag not set");
  property p_ch0_soft_reset;
    @(posedge clk_i) disable iff (reset_i)
      ch0_soft_reset_i |=> ch0_flags == 2'h2 && ch0_en[0] == 1'b0;
  endproperty
  a_ch0_soft_reset: assert property (p_ch0_soft_reset) else $error("ch0 srst lost");
  // read byte is captured at acceptance, so $past lines up with it
  property p_ch0_flag_read;
    @(posedge clk_i) disable iff (reset_i)
      s_axi_arvalid_i & ~b_reg.rvalid & (s_axi_araddr_i == SIRQ_OFS_CH0_FLAGS)
      |=> s_axi_rdata_o[1:0] == $past(ch0_flags);
  endproperty
  a_ch0_flag_read: assert property (p_ch0_flag_read) else $error("ch0 flag read bad");
  property p_ch0_en_read;
    @(posedge clk_i) disable iff (reset_i)
      s_axi_arvalid_i & ~b_reg.rvalid & (s_axi_araddr_i == SIRQ_OFS_CH0_ENABLES)
      |=> s_axi_rdata_o[7:0] == {$past(ch0_foreign_enables_i), $past(ch0_en)};
  endproperty
  a_ch0_en_read: assert property (p_ch0_en_read) else $error("ch0 enable read bad");
  property p_ch1_en_read;
    @(posedge clk_i) disable iff (reset_i)
      s_axi_arvalid_i & ~b_reg.rvalid & (s_axi_araddr_i == SIRQ_OFS_CH1_ENABLES)
      |=> s_axi_rdata_o[7:0] == {4'h0, $past(ch1_foreign_i), $past(ch1_en)};
  endproperty
  a_ch1_en_read: assert property (p_ch1_en_read) else $error("ch1 enable read bad");
  property p_ch1_flag_read;
    @(posedge clk_i) disable iff (reset_i)
      s_axi_arvalid_i & ~b_reg.rvalid & (s_axi_araddr_i == SIRQ_OFS_CH1_FLAGS)
      |=> s_axi_rdata_o[7:0] == {4'h0, $past(ch1_foreign_i), $past(ch1_flags)};
  endproperty
  a_ch1_flag_read: assert property (p_ch1_flag_read) else $error("ch1 flag read bad");
  property p_ch0_clear;
    @(posedge clk_i) disable iff (reset_i)
      we_f0 & ~b_reg.wdata[SIRQ_BIT_RX] & ~ch0_rx_done_i & ~ch0_soft_reset_i |=> ~ch0_flags[0];
  endproperty
  a_ch0_clear: assert property (p_ch0_clear) else $error("ch0 rx clear lost");
  property p_ch0_tx_clear;
    @(posedge clk_i) disable iff (reset_i)
      we_f0 & ~b_reg.wdata[SIRQ_BIT_TX] & ~ch0_tx_empty_i & ~ch0_soft_reset_i |=> ~ch0_flags[1];
  endproperty
  a_ch0_tx_clear: assert property (p_ch0_tx_clear) else $error("ch0 tx clear lost");
  property p_ch1_tx_clear;
    @(posedge clk_i) disable iff (reset_i)
      we_f1 & ~b_reg.wdata[SIRQ_BIT_TX] & ~ch1_tx_empty_i & ~ch1_soft_reset_i |=> ~ch1_flags[1];
  endproperty
  a_ch1_tx_clear: assert property (p_ch1_tx_clear) else $error("ch1 tx clear lost");
  property p_ch1_rx_irq;
    @(posedge clk_i) disable iff (reset_i) ##1 ch1_rx_irq_o == $past(ch1_flags[0] & ch1_en[0]);
  endproperty
  a_ch1_rx_irq: assert property (p_ch1_rx_irq) else $error("ch1 rx request mismatch");
  property p_ch0_rx_irq;
    @(posedge clk_i) disable iff (reset_i) ##1 ch0_rx_irq_o == $past(ch0_flags[0] & ch0_en[0]);
  endproperty
  a_ch0_rx_irq: assert property (p_ch0_rx_irq) else $error("ch0 rx request mismatch");
  property p_ch1_tx_irq;
    @(posedge clk_i) disable iff (reset_i) ##1 ch1_tx_irq_o == $past(ch1_flags[1] & ch1_en[1]);
  endproperty
  a_ch1_tx_irq: assert property (p_ch1_tx_irq) else $error("ch1 tx request mismatch");
  c_write: cover property (@(posedge clk_i) disable iff (reset_i) s_axi_bvalid_o & s_axi_bready_i);
  c_read: cover property (@(posedge clk_i) disable iff (reset_i) s_axi_rvalid_o & s_axi_rready_i);
  c_irq: cover property (@(posedge clk_i) disable iff (reset_i) ch1_rx_irq_o);
  c_srst: cover property (@(posedge clk_i) disable iff (reset_i) ch0_soft_reset_i);
  c_tx_irq: cover property (@(posedge clk_i) disable iff (reset_i) ch1_tx_irq_o);
endmodule

// ### sirq_pkg.sv
// package for the serial port interrupt flag and enable register bank
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock
package sirq_pkg;
  // =====================================================
  // register byte addresses
  localparam logic [3:0] SIRQ_OFS_CH0_FLAGS = 4'h0;
  localparam logic [3:0] SIRQ_OFS_CH0_ENABLES = 4'h4;
  localparam logic [3:0] SIRQ_OFS_CH1_ENABLES = 4'h8;
  localparam logic [3:0] SIRQ_OFS_CH1_FLAGS = 4'hC;
  // =====================================================
  // field positions
  localparam int SIRQ_BIT_TX = 1;
  localparam int SIRQ_BIT_RX = 0;
  // =====================================================
  // reset values
  localparam logic [7:0] SIRQ_RST_FLAGS = 8'h02;
  localparam logic [7:0] SIRQ_RST_ENABLES = 8'h00;
  // channel 1 bits 7-4 unused, bits 3-2 serve other modules
  localparam logic [7:0] SIRQ_CH1_FOREIGN_MASK = 8'h0C;
  // channel 0 bits 7-2 belong to other modules
  localparam logic [7:0] SIRQ_CH0_FOREIGN_MASK = 8'hFC;
  localparam logic [7:0] SIRQ_OWN_MASK = 8'h03;
  // =====================================================
  // axi responses
  localparam logic [1:0] SIRQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] SIRQ_RESP_SLVERR = 2'h2;

  // address match against one register offset
  function automatic logic sirq_hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction
endpackage

// ### sirq_chan.sv
// one channel: tx-empty and rx-complete flags with enables
// assumes event inputs are synchronous to clk_i
`timescale 1ns/1ps
module sirq_chan
  import sirq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire logic tx_empty_i,
  input wire logic rx_done_i,
  input wire logic flag_we_i,
  input wire logic [1:0] flag_wdata_i,
  input wire logic en_we_i,
  input wire logic [1:0] en_wdata_i,
  output logic [1:0] flags_o,
  output logic [1:0] enables_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);
  typedef struct packed {
    logic tx_flag;
    logic rx_flag;
    logic tx_en;
    logic rx_en;
    logic tx_irq;
    logic rx_irq;
  } sirq_chan_t;
  sirq_chan_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (flag_we_i) begin
      s_next.tx_flag = flag_wdata_i[SIRQ_BIT_TX];
      s_next.rx_flag = flag_wdata_i[SIRQ_BIT_RX];
    end
    if (en_we_i) begin
      s_next.tx_en = en_wdata_i[SIRQ_BIT_TX];
      s_next.rx_en = en_wdata_i[SIRQ_BIT_RX];
    end
    // set wins over a software clear in the same cycle
    if (tx_empty_i) begin
      s_next.tx_flag = 1'b1;
    end
    if (rx_done_i) begin
      s_next.rx_flag = 1'b1;
    end
    if (soft_reset_i) begin
      s_next.rx_flag = 1'b0;
      s_next.rx_en = 1'b0;
      s_next.tx_flag = 1'b1;
    end
    // request follows the registered flag and enable, one cycle late
    s_next.tx_irq = s_reg.tx_flag & s_reg.tx_en;
    s_next.rx_irq = s_reg.rx_flag & s_reg.rx_en;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '{tx_flag: SIRQ_RST_FLAGS[SIRQ_BIT_TX], rx_flag: SIRQ_RST_FLAGS[SIRQ_BIT_RX],
                 tx_en: SIRQ_RST_ENABLES[SIRQ_BIT_TX], rx_en: SIRQ_RST_ENABLES[SIRQ_BIT_RX],
                 tx_irq: 1'b0, rx_irq: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags_o = {s_reg.tx_flag, s_reg.rx_flag};
  assign enables_o = {s_reg.tx_en, s_reg.rx_en};
  assign tx_irq_o = s_reg.tx_irq;
  assign rx_irq_o = s_reg.rx_irq;
endmodule

// ### sirq_regs_tb_top.sv
// testbench for the serial port interrupt flag and enable register bank
// assumes sirq_pkg is compiled first; the bench is the axi4-lite master
`timescale 1ns/1ps
module sirq_regs_tb_top
  import sirq_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] srst = 2'h0, txe = 2'h0, rxd = 2'h0, c1f = 2'h0;
  logic [5:0] c0ff = 6'h0, c0fe = 6'h0;
  logic [3:0] irq;
  logic snap = 1'b0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [3:0] iq[$];
  int num_errors = 0, checks_done = 0, cycles = 0;

  always #5 clk_i = ~clk_i;

  sirq_regs dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .ch0_soft_reset_i(srst[0]), .ch1_soft_reset_i(srst[1]),
    .ch0_tx_empty_i(txe[0]), .ch0_rx_done_i(rxd[0]),
    .ch1_tx_empty_i(txe[1]), .ch1_rx_done_i(rxd[1]),
    .ch0_foreign_flags_i(c0ff), .ch0_foreign_enables_i(c0fe), .ch1_foreign_i(c1f),
    .ch0_tx_irq_o(irq[0]), .ch0_rx_irq_o(irq[1]),
    .ch1_tx_irq_o(irq[2]), .ch1_rx_irq_o(irq[3])
  );

  // ==========================================
  // compare and verdict
  task automatic cmp_read(input logic [33:0] exp, input logic [33:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR read expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmp_bresp(input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR bresp expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmp_irq(input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR irq expected %h seen %h", exp, got);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // negedge sampling sees what the next rising edge will take
  always @(negedge clk_i) begin
    if (rvalid === 1'b1 && rready) cmp_read(rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready) cmp_bresp(bq.pop_front(), bresp);
    if (snap) cmp_irq(iq.pop_front(), irq);
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================
  // bus and event drivers
  function automatic logic [7:0] ex(input logic [3:0] a, input logic [1:0] own);
    case (a)
      SIRQ_OFS_CH0_FLAGS: return {c0ff, own};
      SIRQ_OFS_CH0_ENABLES: return {c0fe, own};
      default: return {4'h0, c1f, own};
    endcase
  endfunction

  task automatic wr(input logic [3:0] a, input logic [1:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic aw_t, w_t, b_t;
    bq.push_back(r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {30'($urandom), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge clk_i);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      @(posedge clk_i);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    logic a_t, r_t;
    rq.push_back({r, 24'h0, d});
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge clk_i);
      a_t = arvalid && arready;
      r_t = rvalid && rready;
      @(posedge clk_i);
      if (a_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic chk_irq(input logic [3:0] e);
    iq.push_back(e);
    @(posedge clk_i);
    snap <= 1'b1;
    @(posedge clk_i);
    snap <= 1'b0;
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [3:0] ofs [4];
    int i;
    ofs = '{SIRQ_OFS_CH0_FLAGS, SIRQ_OFS_CH0_ENABLES, SIRQ_OFS_CH1_ENABLES, SIRQ_OFS_CH1_FLAGS};
    void'($urandom(79));
    c0ff <= 6'($urandom);
    c0fe <= 6'($urandom);
    c1f <= 2'($urandom);
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd(ofs[i], ex(ofs[i], (i % 3 == 0) ? 2'b10 : 2'b00), SIRQ_RESP_OKAY);
    end
    chk_irq(4'h0);
    wr(ofs[1], 2'b11, 4'hF, SIRQ_RESP_OKAY);
    wr(ofs[2], 2'b11, 4'hF, SIRQ_RESP_OKAY);
    chk_irq(4'h5);
    wr(ofs[0], 2'b00, 4'hF, SIRQ_RESP_OKAY);
    wr(ofs[3], 2'b00, 4'hF, SIRQ_RESP_OKAY);
    chk_irq(4'h0);
    // lane 0 strobe off: write must be dropped
    wr(ofs[0], 2'b11, 4'hE, SIRQ_RESP_OKAY);
    rd(ofs[0], ex(ofs[0], 2'b00), SIRQ_RESP_OKAY);
    rd(ofs[3], ex(ofs[3], 2'b00), SIRQ_RESP_OKAY);
    wr(4'h2, 2'b11, 4'hF, SIRQ_RESP_SLVERR);
    rd(4'h2, 8'h00, SIRQ_RESP_SLVERR);
    @(posedge clk_i);
    txe <= 2'b11;
    rxd <= 2'b11;
    @(posedge clk_i);
    txe <= 2'b00;
    rxd <= 2'b00;
    repeat (2) @(posedge clk_i);
    chk_irq(4'hF);
    rd(ofs[0], ex(ofs[0], 2'b11), SIRQ_RESP_OKAY);
    rd(ofs[3], ex(ofs[3], 2'b11), SIRQ_RESP_OKAY);
    @(posedge clk_i);
    srst <= 2'b11;
    @(posedge clk_i);
    srst <= 2'b00;
    repeat (2) @(posedge clk_i);
    chk_irq(4'h5);
    for (i = 0; i < 4; i++) begin
      rd(ofs[i], ex(ofs[i], 2'b10), SIRQ_RESP_OKAY);
    end
    conclude();
  end
endmodule
